//--- hdl/rps_supervisor.sv
/*
  supply selection, temperature-correction scheduling, oscillator gating,
  open-drain reset pin with power-fail hold-off and pushbutton debounce,
  calendar and alarm / square-wave output, registers over AXI4-Lite.
  assumes supply comparators, reset pin and serial-address strobe from
  outside; the address strobe is already on aclk.
*/
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`include "rps_regs.svh"

module rps_supervisor
  import rps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `RPS_TICK_CYCLES,
  parameter int unsigned REC_CYCLES = `RPS_REC_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = `RPS_PB_DEBOUNCE_CYCLES,
  parameter int unsigned PULSE_CYCLES = `RPS_PB_PULSE_CYCLES,
  parameter logic signed [7:0] FACTORY_TRIM = 8'sh00
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic primary_present,
  input wire logic primary_above_threshold,
  input wire logic primary_above_backup,
  input wire logic serial_address_valid,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic alarm_irq_or_square_wave_out,
  output logic alarm_irq_or_square_wave_oe,
  output logic backup_selected,
  output logic oscillator_running,
  output logic conversion_start,
  output logic correction_apply,
  output logic signed [8:0] correction_value
);

  logic [3:0] sync1, sync2;
  logic pin_q;
  logic present_s, above_pf_s, above_bat_s, pin_s, primary_ok, ok_q;
  logic [31:0] pre, next_pre;
  logic [5:0] sec, next_sec, min, next_min;
  logic [4:0] hour, next_hour, date, next_date;
  logic pm, next_pm, mode12, next_mode12, century, next_century;
  logic [2:0] wday, next_wday;
  logic [3:0] month, next_month, per_cnt, next_per_cnt;
  logic [6:0] year, next_year;
  logic [21:0] alarm1, next_alarm1, alarm2, next_alarm2;
  logic [7:0] ctrl, next_ctrl, aging, next_aging;
  logic a1f, next_a1f, a2f, next_a2f, tick_q, next_tick_q;
  logic osc_started, next_osc_started, primary_seen, next_primary_seen;
  logic start_pend, next_start_pend;
  logic [1:0] start_cnt, next_start_cnt;
  logic tick, c_min, c_hour, c_day, c_mon, c_year, load_cal, start_evt, fire;
  logic wr_go, rd_go;
  logic [31:0] wr_word;
  logic [31:0] cur_time;
  rps_pb_e pb_state, next_pb_state;
  logic [31:0] pb_cnt, next_pb_cnt, rec_cnt, next_rec_cnt;
  logic pin_fall, pin_rise, pf_fail, hold;

  // two-flop synchronisers for pins and comparators
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      pin_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      sync1 <= {reset_pin_in, primary_present, primary_above_threshold, primary_above_backup};
      sync2 <= sync1;
      pin_q <= sync2[3];
      ok_q <= primary_ok;
    end
  end

  assign pin_s = sync2[3];
  assign present_s = sync2[2];
  assign above_pf_s = sync2[1];
  assign above_bat_s = sync2[0];
  assign primary_ok = present_s && above_pf_s;
  assign cur_time = {9'h000, mode12, pm, hour, 2'h0, min, 2'h0, sec};

  // days in a month, binary year 0..99 with every fourth a leap year
  function automatic logic [4:0] month_days(input logic [3:0] m, input logic [6:0] y);
    if (m == 4'h2) begin
      return (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
    end else if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hB) begin
      return 5'h1E;
    end
    return 5'h1F;
  endfunction

  // register read view
  function automatic logic [31:0] reg_word(input logic [7:0] a);
    if (a == `RPS_OFF_TIME) begin
      return cur_time;
    end else if (a == `RPS_OFF_DATE) begin
      return {century, year, 4'h0, month, 3'h0, date, 5'h00, wday};
    end else if (a == `RPS_OFF_ALARM1) begin
      return {10'h000, alarm1};
    end else if (a == `RPS_OFF_ALARM2) begin
      return {10'h000, alarm2};
    end else if (a == `RPS_OFF_CONTROL) begin
      return {24'h000000, ctrl};
    end else if (a == `RPS_OFF_STATUS) begin
      return {27'h0000000, reset_pin_oe, backup_selected, oscillator_running, a2f, a1f};
    end else if (a == `RPS_OFF_AGING) begin
      return {24'h000000, aging};
    end else if (a == `RPS_OFF_CORR) begin
      return {{23{correction_value[8]}}, correction_value};
    end
    return 32'h00000000;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `RPS_OFF_CORR);
  endfunction

  // byte-lane merge of a write into the current register contents
  always_comb begin
    wr_word = reg_word(s_axi_awaddr);
    for (int i = 0; i < 4; i++) begin
      if (s_axi_wstrb[i]) begin
        wr_word[8*i +: 8] = s_axi_wdata[8*i +: 8];
      end
    end
  end

  // next state of time base, calendar, alarms and control
  always_comb begin
    next_sec = sec;
    next_min = min;
    next_hour = hour;
    next_pm = pm;
    next_mode12 = mode12;
    next_wday = wday;
    next_date = date;
    next_month = month;
    next_year = year;
    next_century = century;
    next_alarm1 = alarm1;
    next_alarm2 = alarm2;
    next_ctrl = ctrl;
    next_aging = aging;
    next_start_pend = start_pend;
    next_start_cnt = start_cnt;
    next_per_cnt = per_cnt;
    fire = 1'b0;
    c_day = 1'b0;
    // the 1 Hz tick only runs while the oscillator does; pin activity never enters here
    tick = oscillator_running && (pre == TICK_CYCLES - 1);
    next_pre = oscillator_running ? (tick ? 32'h0 : pre + 32'h1) : pre;
    next_tick_q = tick;
    c_min = tick && (sec == 6'h3B);
    c_hour = c_min && (min == 6'h3B);
    if (tick) begin
      next_sec = c_min ? 6'h00 : sec + 6'h01;
    end
    if (c_min) begin
      next_min = c_hour ? 6'h00 : min + 6'h01;
    end
    // hour step in 24-hour or 12-hour form
    if (c_hour) begin
      if (!mode12) begin
        c_day = (hour == 5'h17);
        next_hour = c_day ? 5'h00 : hour + 5'h01;
      end else if (hour == 5'h0C) begin
        next_hour = 5'h01;
      end else if (hour == 5'h0B) begin
        next_hour = 5'h0C;
        next_pm = !pm;
        c_day = pm;
      end else begin
        next_hour = hour + 5'h01;
      end
    end
    c_mon = c_day && (date == month_days(month, year));
    c_year = c_mon && (month == 4'hC);
    if (c_day) begin
      next_wday = (wday == 3'h7) ? 3'h1 : wday + 3'h1;
      next_date = c_mon ? 5'h01 : date + 5'h01;
    end
    if (c_mon) begin
      next_month = c_year ? 4'h1 : month + 4'h1;
    end
    if (c_year) begin
      next_year = (year == 7'h63) ? 7'h00 : year + 7'h01;
      next_century = century ^ (year == 7'h63);
    end
    // software writes, decoded by address
    if (wr_go) begin
      if (s_axi_awaddr == `RPS_OFF_TIME) begin
        next_sec = wr_word[5:0];
        next_min = wr_word[13:8];
        next_hour = wr_word[20:16];
        next_pm = wr_word[21];
        next_mode12 = wr_word[22];
        next_pre = 32'h0; // writing the time restarts the second
      end else if (s_axi_awaddr == `RPS_OFF_DATE) begin
        next_wday = wr_word[2:0];
        next_date = wr_word[12:8];
        next_month = wr_word[19:16];
        next_year = wr_word[30:24];
        next_century = wr_word[31];
      end else if (s_axi_awaddr == `RPS_OFF_ALARM1) begin
        next_alarm1 = wr_word[21:0];
      end else if (s_axi_awaddr == `RPS_OFF_ALARM2) begin
        next_alarm2 = wr_word[21:0];
      end else if (s_axi_awaddr == `RPS_OFF_CONTROL) begin
        next_ctrl = wr_word[7:0];
      end else if (s_axi_awaddr == `RPS_OFF_AGING) begin
        next_aging = wr_word[7:0];
      end
    end
    // calendar load on first primary power-up or address while on backup
    load_cal = (primary_ok && !ok_q && !primary_seen) ||
               (serial_address_valid && backup_selected);
    next_primary_seen = primary_seen || primary_ok;
    if (load_cal) begin
      next_sec = 6'h00;
      next_min = 6'h00;
      next_hour = 5'h00;
      next_pm = 1'b0;
      next_mode12 = 1'b0;
      next_wday = `RPS_INIT_WDAY;
      next_date = `RPS_INIT_DAY;
      next_month = `RPS_INIT_MONTH;
      next_year = 7'h00;
      next_century = 1'b0;
    end
    // alarm flags: a match sets, a one written clears, the set wins
    next_a1f = (a1f && !(wr_go && s_axi_awaddr == `RPS_OFF_STATUS &&
               s_axi_wstrb[0] && s_axi_wdata[`RPS_STAT_A1_FLAG])) ||
               (tick_q && cur_time[21:0] == alarm1);
    next_a2f = (a2f && !(wr_go && s_axi_awaddr == `RPS_OFF_STATUS &&
               s_axi_wstrb[0] && s_axi_wdata[`RPS_STAT_A2_FLAG])) ||
               (tick_q && sec == 6'h00 && cur_time[21:8] == alarm2[21:8]);
    // oscillator gate: stays stopped until primary is good or addressed
    next_osc_started = osc_started || primary_ok || serial_address_valid;
    // startup conversion two ticks after primary or address arrives
    start_evt = (primary_ok && !ok_q) || serial_address_valid;
    if (start_evt) begin
      next_start_pend = 1'b1;
      next_start_cnt = 2'h0;
    end else if (start_pend && tick) begin
      if (start_cnt == 2'(`RPS_START_DELAY_S - 1)) begin
        next_start_pend = 1'b0;
        fire = 1'b1;
      end else begin
        next_start_cnt = start_cnt + 2'h1;
      end
    end
    // periodic conversion: every tick on primary, every tenth on backup
    if (tick) begin
      if (!backup_selected) begin
        next_per_cnt = 4'h0;
        fire = 1'b1;
      end else if (per_cnt == 4'(`RPS_BACKUP_PERIOD_S - 1)) begin
        next_per_cnt = 4'h0;
        fire = 1'b1;
      end else begin
        next_per_cnt = per_cnt + 4'h1;
      end
    end
  end

  // registers of time base, calendar, alarms and control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre <= 32'h0;
      sec <= 6'h00;
      min <= 6'h00;
      hour <= 5'h00;
      pm <= 1'b0;
      mode12 <= 1'b0;
      wday <= `RPS_INIT_WDAY;
      date <= `RPS_INIT_DAY;
      month <= `RPS_INIT_MONTH;
      year <= 7'h00;
      century <= 1'b0;
      alarm1 <= 22'h000000;
      alarm2 <= 22'h000000;
      ctrl <= `RPS_CTRL_RESET;
      aging <= 8'h00;
      a1f <= 1'b0;
      a2f <= 1'b0;
      tick_q <= 1'b0;
      osc_started <= 1'b0;
      primary_seen <= 1'b0;
      start_pend <= 1'b0;
      start_cnt <= 2'h0;
      per_cnt <= 4'h0;
      oscillator_running <= 1'b0;
      backup_selected <= 1'b0;
      conversion_start <= 1'b0;
      correction_apply <= 1'b0;
      correction_value <= 9'sh000;
      alarm_irq_or_square_wave_out <= 1'b0;
      alarm_irq_or_square_wave_oe <= 1'b0;
    end else begin
      pre <= next_pre;
      sec <= next_sec;
      min <= next_min;
      hour <= next_hour;
      pm <= next_pm;
      mode12 <= next_mode12;
      wday <= next_wday;
      date <= next_date;
      month <= next_month;
      year <= next_year;
      century <= next_century;
      alarm1 <= next_alarm1;
      alarm2 <= next_alarm2;
      ctrl <= next_ctrl;
      aging <= next_aging;
      a1f <= next_a1f;
      a2f <= next_a2f;
      tick_q <= next_tick_q;
      osc_started <= next_osc_started;
      primary_seen <= next_primary_seen;
      start_pend <= next_start_pend;
      start_cnt <= next_start_cnt;
      per_cnt <= next_per_cnt;
      oscillator_running <= next_osc_started && !next_ctrl[`RPS_CTRL_OSC_DIS_N];
      backup_selected <= !(above_pf_s || above_bat_s);
      conversion_start <= fire;
      correction_apply <= fire;
      if (fire) begin
        correction_value <= 9'(FACTORY_TRIM) + 9'($signed(aging));
      end
      alarm_irq_or_square_wave_out <= 1'b0;
      alarm_irq_or_square_wave_oe <= ctrl[`RPS_CTRL_OUT_SEL] ?
        ((a1f && ctrl[`RPS_CTRL_A1_EN]) || (a2f && ctrl[`RPS_CTRL_A2_EN])) :
        (pre >= TICK_CYCLES / 2);
    end
  end

  // next state of reset pin: power-fail, recovery hold and pushbutton
  always_comb begin
    pin_fall = pin_q && !pin_s;
    pin_rise = !pin_q && pin_s;
    pf_fail = present_s && !above_pf_s;
    next_rec_cnt = rec_cnt;
    if (pf_fail) begin
      next_rec_cnt = REC_CYCLES;
    end else if (!oscillator_running) begin
      next_rec_cnt = 32'h0;
    end else if (rec_cnt != 32'h0) begin
      next_rec_cnt = rec_cnt - 32'h1;
    end
    hold = pf_fail || (rec_cnt != 32'h0);
    next_pb_state = pb_state;
    next_pb_cnt = pb_cnt;
    if (!present_s || hold) begin
      next_pb_state = PB_IDLE;
      next_pb_cnt = 32'h0;
    end else begin
      case (pb_state)
        PB_IDLE: begin
          if (pin_fall) begin
            next_pb_state = PB_DEBOUNCE;
            next_pb_cnt = DEBOUNCE_CYCLES - 1;
          end
        end
        PB_DEBOUNCE: begin
          if (pb_cnt == 32'h0) begin
            next_pb_state = PB_WAIT_RISE;
          end else begin
            next_pb_cnt = pb_cnt - 32'h1;
          end
        end
        PB_WAIT_RISE: begin
          if (pin_rise) begin
            next_pb_state = PB_PULSE;
            next_pb_cnt = PULSE_CYCLES - 1;
          end
        end
        default: begin
          if (pb_cnt == 32'h0) begin
            next_pb_state = PB_IDLE;
          end else begin
            next_pb_cnt = pb_cnt - 32'h1;
          end
        end
      endcase
    end
  end

  // registers of reset pin logic; without primary the pin stays low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rec_cnt <= 32'h0;
      pb_state <= PB_IDLE;
      pb_cnt <= 32'h0;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b1;
    end else begin
      rec_cnt <= next_rec_cnt;
      pb_state <= next_pb_state;
      pb_cnt <= next_pb_cnt;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= !present_s || hold || pb_state == PB_DEBOUNCE ||
                      pb_state == PB_PULSE;
    end
  end

  // axi4-lite slave, served in every supply state
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RPS_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RPS_RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(s_axi_awaddr) ? `RPS_RESP_OKAY : `RPS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= reg_word(s_axi_araddr);
        s_axi_rresp <= addr_ok(s_axi_araddr) ? `RPS_RESP_OKAY : `RPS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  a_supply_select: assert property (@(posedge aclk) disable iff (!aresetn)
    (!above_pf_s && !above_bat_s) |=> backup_selected)
    else $error("backup not selected with primary low");
  a_power_fail_low: assert property (@(posedge aclk) disable iff (!aresetn)
    pf_fail |=> reset_pin_oe ##1 reset_pin_oe)
    else $error("reset pin released during power fail");
  a_no_primary_low: assert property (@(posedge aclk) disable iff (!aresetn)
    !present_s |=> reset_pin_oe && pb_state == PB_IDLE)
    else $error("reset pin not held low without primary");
  a_backup_conv_gap: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && backup_selected && per_cnt != 4'h9 && !start_pend) |=> !conversion_start)
    else $error("backup conversion before tenth tick");
  a_corr_value_sum: assert property (@(posedge aclk) disable iff (!aresetn)
    conversion_start |-> correction_apply &&
    correction_value == 9'(FACTORY_TRIM) + 9'($signed($past(aging))))
    else $error("correction value not trim plus aging");
  a_osc_disable_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl[`RPS_CTRL_OSC_DIS_N] && !oscillator_running) |=> $stable(sec) && $stable(pre))
    else $error("timekeeping advanced with oscillator stopped");
  a_rec_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(primary_ok) && !oscillator_running && pb_state == PB_IDLE) |=> ##1 !reset_pin_oe)
    else $error("recovery hold not bypassed");
  a_rec_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    ($fell(pf_fail) && present_s && oscillator_running && REC_CYCLES > 8) |=>
    reset_pin_oe [*8])
    else $error("reset pin released early after power fail");
  a_pb_debounce: assert property (@(posedge aclk) disable iff (!aresetn)
    (pb_state == PB_IDLE && pin_fall && !hold && present_s) |=>
    pb_state == PB_DEBOUNCE ##1 reset_pin_oe)
    else $error("falling edge did not start debounce");

endmodule

//--- hdl/rps_regs.svh
/*
  register offsets, field positions, reset values and timing counts of the
  supply and reset supervisor.
  assumes a 200 MHz aclk and 32-bit AXI4-Lite words at byte addresses.
*/
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH

// clock and time figures, counts derived from them
`define RPS_CLK_PERIOD_NS 5
`define RPS_TICK_TIME_MS 1000
`define RPS_TICK_CYCLES ((`RPS_TICK_TIME_MS * 1000000) / `RPS_CLK_PERIOD_NS)
`define RPS_REC_TIME_MS 250
`define RPS_REC_CYCLES ((`RPS_REC_TIME_MS * 1000000) / `RPS_CLK_PERIOD_NS)
`define RPS_PB_DEBOUNCE_CYCLES 50000
`define RPS_PB_PULSE_CYCLES 50000
`define RPS_START_DELAY_S 2
`define RPS_BACKUP_PERIOD_S 10

// register byte offsets
`define RPS_OFF_TIME 8'h00
`define RPS_OFF_DATE 8'h04
`define RPS_OFF_ALARM1 8'h08
`define RPS_OFF_ALARM2 8'h0C
`define RPS_OFF_CONTROL 8'h10
`define RPS_OFF_STATUS 8'h14
`define RPS_OFF_AGING 8'h18
`define RPS_OFF_CORR 8'h1C

// control and status fields
`define RPS_CTRL_OSC_DIS_N 7
`define RPS_CTRL_OUT_SEL 2
`define RPS_CTRL_A2_EN 1
`define RPS_CTRL_A1_EN 0
`define RPS_CTRL_RESET 8'h04
`define RPS_STAT_A1_FLAG 0
`define RPS_STAT_A2_FLAG 1

// calendar load value: day 1, month 1, year 0, weekday 1, 00:00:00
`define RPS_INIT_DAY 5'h01
`define RPS_INIT_MONTH 4'h1
`define RPS_INIT_WDAY 3'h1

// axi responses
`define RPS_RESP_OKAY 2'h0
`define RPS_RESP_SLVERR 2'h2

`endif

//--- hdl/rps_pkg.sv
/*
  types of the supply and reset supervisor.
  assumes nothing beyond a SystemVerilog compiler.
*/
package rps_pkg;

  // pushbutton monitor states
  typedef enum logic [1:0] {
    PB_IDLE = 2'b00,
    PB_DEBOUNCE = 2'b01,
    PB_WAIT_RISE = 2'b10,
    PB_PULSE = 2'b11
  } rps_pb_e;

endpackage

//--- verification/rps_pin_model.sv
/*
  pushbutton on the open-drain reset pin, together with the pin's pull-up.
  assumes oe high means the supervisor pulls the pin low.
*/
module rps_pin_model (
  input wire logic press,
  input wire logic oe,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up wins unless the button or the supervisor pulls low
  assign pin = !(press || oe);
endmodule

//--- verification/rps_supervisor_tb.sv
/*
  bench of the supply and reset supervisor: reset state, registers,
  correction period, pushbutton and power fail.
  assumes the design files and the pin model are compiled first.
*/
`include "rps_regs.svh"

module rps_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 100, RC = 20, DB = 10, PL = 10, LIM = 3000;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic primary_present = 0, primary_above_threshold = 0, primary_above_backup = 0;
  logic serial_address_valid = 0, press = 0, reset_pin_in, reset_pin_out, reset_pin_oe;
  logic alarm_irq_or_square_wave_out, alarm_irq_or_square_wave_oe, backup_selected;
  logic oscillator_running, conversion_start, correction_apply;
  logic signed [8:0] correction_value;
  logic [3:0] mon;
  logic [33:0] rd;
  int bad_count = 0, compares = 0;
  // watched bits: 0 pin pull, 1 oscillator, 2 backup, 3 correction
  assign mon = {correction_apply, backup_selected, oscillator_running, reset_pin_oe};
  // 200 MHz clock
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  rps_supervisor #(.TICK_CYCLES(TK), .REC_CYCLES(RC), .DEBOUNCE_CYCLES(DB),
    .PULSE_CYCLES(PL)) rps_supervisor_inst (.*);
  rps_pin_model rps_pin_model_inst (.press(press), .oe(reset_pin_oe), .pin(reset_pin_in));
  // verdict and end of run
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= LIM) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  // outputs are read right after an edge, so they show the sampled value
  task automatic wait_bit(input int b, input logic v);
    int n = 0;
    while (mon[b] !== v && n < LIM) begin
      @(posedge aclk);
      n++;
    end
    tmo(n);
  endtask
  task automatic run_len(input int b, input logic v, output int c);
    c = 0;
    while (mon[b] === v && c < LIM) begin
      @(posedge aclk);
      c++;
    end
    tmo(c);
  endtask
  task automatic period(output int p);
    wait_bit(3, 1'b1);
    @(posedge aclk);
    run_len(3, 1'b0, p);
    p++;
  endtask
  // axi write, response code left in rd
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    // let an edge pass so a strobe is never set twice in one step
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_awready !== 1'b1 && n < LIM);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < LIM);
    s_axi_bready <= 1'b0;
    rd = {s_axi_bresp, 32'h0};
    tmo(n);
  endtask
  // axi read, response and data left in rd
  task automatic axi_rd(input logic [7:0] a);
    int n = 0;
    // let an edge pass so a strobe is never set twice in one step
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_arready !== 1'b1 && n < LIM);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < LIM);
    s_axi_rready <= 1'b0;
    rd = {s_axi_rresp, s_axi_rdata};
    tmo(n);
  endtask
  task automatic t_reset();
    chk(reset_pin_oe, 1'b1);
    chk(oscillator_running, 1'b0);
    chk({reset_pin_out, alarm_irq_or_square_wave_out, alarm_irq_or_square_wave_oe}, 3'h0);
    axi_rd(`RPS_OFF_CONTROL);
    chk(rd, {`RPS_RESP_OKAY, 32'h04});
    axi_rd(8'h20);
    chk(rd[33:32], `RPS_RESP_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_power_up();
    primary_present <= 1'b1;
    primary_above_threshold <= 1'b1;
    primary_above_backup <= 1'b1;
    wait_bit(1, 1'b1);
    chk(backup_selected, 1'b0);
    axi_rd(`RPS_OFF_DATE);
    chk(rd, {`RPS_RESP_OKAY, 32'h00010101});
    wait_bit(0, 1'b0);
    $display("test power up done");
  endtask
  task automatic t_aging();
    int p;
    axi_wr(`RPS_OFF_AGING, 32'hFB);
    chk(rd[33:32], `RPS_RESP_OKAY);
    period(p);
    chk(p, TK);
    chk(conversion_start, 1'b1);
    chk({25'h0, correction_value}, 34'h1FB);
    $display("test aging done");
  endtask
  task automatic t_button();
    int c;
    press <= 1'b1;
    wait_bit(0, 1'b1);
    run_len(0, 1'b1, c);
    chk(c, DB);
    repeat (4) @(posedge aclk);
    chk(reset_pin_oe, 1'b0);
    press <= 1'b0;
    wait_bit(0, 1'b1);
    run_len(0, 1'b1, c);
    chk(c, PL);
    chk(oscillator_running, 1'b1);
    $display("test button done");
  endtask
  // square wave, oscillator stop and restart through the control register
  task automatic t_control();
    int c = 0;
    logic [33:0] t;
    axi_wr(`RPS_OFF_CONTROL, 32'h00);
    repeat (TK) begin
      @(posedge aclk);
      c += alarm_irq_or_square_wave_oe;
    end
    chk(c, TK / 2);
    axi_wr(`RPS_OFF_CONTROL, 32'h84);
    chk(oscillator_running, 1'b0);
    axi_rd(`RPS_OFF_TIME);
    t = rd;
    repeat (2 * TK) @(posedge aclk);
    axi_rd(`RPS_OFF_TIME);
    chk(rd, t);
    axi_wr(`RPS_OFF_CONTROL, 32'h04);
    chk(oscillator_running, 1'b1);
    @(posedge aclk);
    chk(alarm_irq_or_square_wave_oe, 1'b0);
    $display("test control done");
  endtask
  task automatic t_fail();
    int p;
    primary_above_threshold <= 1'b0;
    wait_bit(0, 1'b1);
    repeat (3) @(posedge aclk);
    chk(backup_selected, 1'b0);
    primary_above_backup <= 1'b0;
    wait_bit(2, 1'b1);
    period(p);
    chk(p, 10 * TK);
    chk(oscillator_running, 1'b1);
    // host, its bus recovered, addresses the device while on backup
    serial_address_valid <= 1'b1;
    @(posedge aclk);
    serial_address_valid <= 1'b0;
    run_len(3, 1'b0, p);
    chk(p >= 2 * TK - 4 && p <= 2 * TK, 1'b1);
    axi_rd(`RPS_OFF_TIME);
    chk(rd, {`RPS_RESP_OKAY, 32'h00000002});
    primary_above_threshold <= 1'b1;
    primary_above_backup <= 1'b1;
    wait_bit(2, 1'b0);
    run_len(0, 1'b1, p);
    chk(p >= RC - 2 && p <= RC + 6, 1'b1);
    $display("test power fail done");
  endtask
  // reset, then the scenarios in order
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_power_up();
    t_aging();
    t_button();
    t_control();
    t_fail();
    report_and_stop();
  end
endmodule
